// ### design/uip_cfg.svh
/*
 * register offsets, field positions, reset values and lookup figures
 * for the interrupt priority and line format block.
 * assumes a 32-bit AHB-Lite slave, one aligned word per register.
 */
`ifndef UIP_CFG_SVH
`define UIP_CFG_SVH
// ***********************************************
// register byte offsets
// ***********************************************
`define UIP_OFS_IRQ_STATUS 8'h00
`define UIP_OFS_LINE_FMT 8'h04
`define UIP_OFS_QUEUE_CTRL 8'h08
`define UIP_OFS_ENH_FUNC 8'h0C
`define UIP_OFS_DIVISOR 8'h10
`define UIP_OFS_IRQ_ENABLE 8'h14
`define UIP_OFS_BLOCK_STATE 8'h18
// ***********************************************
// field positions
// ***********************************************
`define UIP_LF_DIV_ACCESS 7
`define UIP_LF_BREAK 6
`define UIP_LF_PFORCE 5
`define UIP_LF_PEVEN 4
`define UIP_LF_PEN 3
`define UIP_LF_STOP 2
`define UIP_QC_ENABLE 0
`define UIP_QC_TXTRIG_LO 4
`define UIP_QC_TXTRIG_HI 5
`define UIP_EF_ENH 4
// ***********************************************
// reset values
// ***********************************************
`define UIP_LINE_FMT_RST 8'h00
`define UIP_QUEUE_RST 8'h00
`define UIP_ENH_RST 8'h00
`define UIP_DIV_RST 16'h0000
`define UIP_IRQ_EN_RST 7'h00
// ***********************************************
// status codes and thresholds
// ***********************************************
`define UIP_CODE_NONE 6'h01
`define UIP_CODE_LS 6'h06
`define UIP_CODE_RXD 6'h04
`define UIP_CODE_RTO 6'h0C
`define UIP_CODE_THR 6'h02
`define UIP_CODE_MSC 6'h00
`define UIP_CODE_XOFF 6'h10
`define UIP_CODE_FLOW 6'h20
`define UIP_TXTRIG_0 7'h08
`define UIP_TXTRIG_1 7'h10
`define UIP_TXTRIG_2 7'h20
`define UIP_TXTRIG_3 7'h38
`define UIP_STOP_ONE 3'h2
`define UIP_STOP_ONE_HALF 3'h3
`define UIP_STOP_TWO 3'h4
`endif

// ### design/uip_pkg.sv
/*
 * types for the interrupt priority and line format block.
 * assumes uip_cfg.svh supplies the numeric constants.
 */
package uip_pkg;
   // ***********************************************
   // interrupt sources, highest priority first
   // ***********************************************
   typedef enum {
      UIP_SRC_LS, UIP_SRC_RXD, UIP_SRC_RTO, UIP_SRC_THR,
      UIP_SRC_MSC, UIP_SRC_XOFF, UIP_SRC_FLOW
   } uip_src_t;
   // event pulses; bit 0 is line status
   typedef struct packed {
      logic flow_change;
      logic xoff_match;
      logic modem_change;
      logic thr_empty;
      logic rx_timeout;
      logic rx_data;
      logic line_status;
   } uip_evt_t;
   // character format handed to transmitter and receiver
   typedef struct packed {
      logic [3:0] char_bits;
      logic [2:0] stop_halves;
      logic parity_en;
      logic parity_even;
      logic parity_force;
      logic break_on;
   } uip_fmt_t;
   typedef enum {UIP_REP_IDLE, UIP_REP_HELD} uip_rep_t;
endpackage

// ### design/uip_top.sv
/*
 * interrupt prioritisation, transmit threshold and line format
 * control of one serial channel, with an AHB-Lite register slave.
 * assumes event pulses, levels and characters come from channel
 * logic on hclk, and the master leaves htrans idle in data phases.
 */
// Operation
// - transmit threshold from trigger code: 8, 16, 32 or 56 characters.
// - seven priority levels; status read returns the held source code, else the highest pending one.
// - no other source is taken while a reported one is unserviced.
// - status read clears only the reported source; lower ones follow.
// - line status is top priority, code bits 2 and 1 set.
// - received data code bit 2; receive timeout bits 3 and 2.
// - holding register empty is fourth priority, code bit 1 only.
// - modem change code zero; xoff bit 4; flow change bit 5.
// - the two upper code bits appear only with enhanced mode enabled.
// - xoff status stays set until matching xon arrives.
// - status bits 7:6 are ones while queues enabled, else zeros.
// - status bit 0 is zero when pending, one when none.
// - divisor and enhanced register reachable only with divisor access set.
// - break bit forces serial output low until software clears it.
// - parity enable adds a parity bit and checks received parity.
// - parity type zero selects odd, one selects even.
// - forced parity gives constant one for type zero, zero for one.
// - stop length one gives 1.5 bits at 5-bit, else two.
// - char size code 00..11 gives 5 to 8 bits.
// - queues on with enable bit; other bits written only with it set.
`timescale 1ns/1ps
`include "uip_cfg.svh"
module uip_top
   import uip_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // channel events and levels
   input wire uip_evt_t evt,
   input wire logic xon_match,
   input wire logic [6:0] tx_level,
   // characters and serial line
   input wire logic [7:0] tx_char,
   input wire logic tx_serial,
   input wire logic [7:0] rx_char,
   input wire logic rx_parity_bit,
   // results
   output logic irq,
   output logic tx_pin,
   output logic tx_parity,
   output logic rx_parity_err,
   output uip_fmt_t fmt,
   output logic queues_on,
   output logic [6:0] tx_threshold,
   output logic [15:0] divisor
);
   // ***********************************************
   // state
   // ***********************************************
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [7:0] lfc_r;
   logic [7:0] qc_r;
   logic [7:0] efc_r;
   logic [15:0] div_r;
   logic [6:0] ien_r;
   logic [6:0] pend_r;
   logic [6:0] pend_nxt;
   uip_rep_t rep_r;
   uip_src_t held_r;
   logic below_r;
   logic irq_r;
   logic tx_pin_r;
   logic tx_par_r;
   logic rx_err_r;
   uip_fmt_t fmt_r;
   logic [6:0] thr_r;
   logic take;
   logic stat_rd;
   logic [6:0] elig;
   logic cur_valid;
   logic held_live;
   uip_src_t top_idx;
   uip_src_t cur_idx;
   logic [6:0] set_v;
   logic [6:0] clr_v;
   logic below;
   logic thr_set;
   logic [31:0] rd_val;

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [6:0] trig_of(input logic [1:0] c);
      unique case (c)
         2'h0: trig_of = `UIP_TXTRIG_0;
         2'h1: trig_of = `UIP_TXTRIG_1;
         2'h2: trig_of = `UIP_TXTRIG_2;
         2'h3: trig_of = `UIP_TXTRIG_3;
      endcase
   endfunction

   function automatic logic [5:0] code_of(input uip_src_t s);
      unique case (s)
         UIP_SRC_LS: code_of = `UIP_CODE_LS;
         UIP_SRC_RXD: code_of = `UIP_CODE_RXD;
         UIP_SRC_RTO: code_of = `UIP_CODE_RTO;
         UIP_SRC_THR: code_of = `UIP_CODE_THR;
         UIP_SRC_MSC: code_of = `UIP_CODE_MSC;
         UIP_SRC_XOFF: code_of = `UIP_CODE_XOFF;
         UIP_SRC_FLOW: code_of = `UIP_CODE_FLOW;
      endcase
   endfunction

   // parity bit over the active character bits
   function automatic logic par_of(input logic [7:0] d,
                                   input logic [7:0] lf);
      logic [7:0] m;
      logic x;
      unique case (lf[1:0])
         2'h0: m = 8'h1F;
         2'h1: m = 8'h3F;
         2'h2: m = 8'h7F;
         2'h3: m = 8'hFF;
      endcase
      x = ^(d & m);
      if (lf[`UIP_LF_PFORCE]) begin
         par_of = ~lf[`UIP_LF_PEVEN];
      end else begin
         par_of = lf[`UIP_LF_PEVEN] ? x : ~x;
      end
   endfunction

   // offsets behind the divisor access bit vanish while it is clear
   function automatic logic acc_ok(input logic [7:0] a,
                                   input logic dla);
      acc_ok = ((a == `UIP_OFS_ENH_FUNC) || (a == `UIP_OFS_DIVISOR))
               ? dla : 1'b1;
   endfunction

   // ***********************************************
   // ahb-lite slave
   // ***********************************************
   assign take = hsel & hready & htrans[1];
   assign stat_rd = take & ~hwrite & (haddr[7:0] == `UIP_OFS_IRQ_STATUS);

   always_comb begin
      rd_val = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000 &&
          acc_ok(haddr[7:0], lfc_r[`UIP_LF_DIV_ACCESS])) begin
         unique case (haddr[7:0])
            `UIP_OFS_IRQ_STATUS: rd_val[7:0] = {{2{qc_r[`UIP_QC_ENABLE]}},
               cur_valid ? code_of(cur_idx) : `UIP_CODE_NONE};
            `UIP_OFS_LINE_FMT: rd_val[7:0] = lfc_r;
            `UIP_OFS_QUEUE_CTRL: rd_val[7:0] = qc_r;
            `UIP_OFS_ENH_FUNC: rd_val[7:0] = efc_r;
            `UIP_OFS_DIVISOR: rd_val[15:0] = div_r;
            `UIP_OFS_IRQ_ENABLE: rd_val[6:0] = ien_r;
            `UIP_OFS_BLOCK_STATE: rd_val[14:0] = {pend_r, 1'b0, thr_r};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   // read data is caught at the address phase so it stands registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= 1'b1;
         if (take && !hwrite) begin
            hrdata_r <= rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= take & hwrite & (haddr[31:8] == 24'h00_0000);
         if (take) begin
            wr_addr_r <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfc_r <= `UIP_LINE_FMT_RST;
         qc_r <= `UIP_QUEUE_RST;
         efc_r <= `UIP_ENH_RST;
         div_r <= `UIP_DIV_RST;
         ien_r <= `UIP_IRQ_EN_RST;
      end else if (wr_pend_r &&
                   acc_ok(wr_addr_r, lfc_r[`UIP_LF_DIV_ACCESS])) begin
         unique case (wr_addr_r)
            `UIP_OFS_LINE_FMT: lfc_r <= hwdata[7:0];
            `UIP_OFS_QUEUE_CTRL: begin
               if (hwdata[`UIP_QC_ENABLE]) begin
                  qc_r <= hwdata[7:0];
               end else begin
                  qc_r <= 8'h00;
               end
            end
            `UIP_OFS_ENH_FUNC: efc_r <= hwdata[7:0];
            `UIP_OFS_DIVISOR: div_r <= hwdata[15:0];
            `UIP_OFS_IRQ_ENABLE: ien_r <= hwdata[6:0];
            default: ;
         endcase
      end
   end

   // ***********************************************
   // source selection
   // ***********************************************
   // a status read is one address phase, so one source clears per read
   assign elig = pend_r & ien_r &
                 {{2{efc_r[`UIP_EF_ENH]}}, 5'h1F};

   always_comb begin
      top_idx = UIP_SRC_FLOW;
      for (int i = 6; i >= 0; i--) begin
         if (elig[i]) begin
            top_idx = uip_src_t'(i);
         end
      end
   end

   // a held source whose flag vanished (xon, enable cleared) lets go
   assign held_live = (rep_r == UIP_REP_HELD) & elig[held_r];
   assign cur_valid = held_live | (|elig);
   assign cur_idx = held_live ? held_r : top_idx;

   assign below = tx_level < thr_r;
   assign thr_set = qc_r[`UIP_QC_ENABLE] ? (below & ~below_r)
                                         : evt.thr_empty;
   assign set_v = {evt.flow_change, evt.xoff_match, evt.modem_change,
                   thr_set, evt.rx_timeout, evt.rx_data,
                   evt.line_status};

   always_comb begin
      clr_v = 7'h00;
      if (stat_rd && cur_valid && cur_idx != UIP_SRC_XOFF) begin
         clr_v[cur_idx] = 1'b1;
      end
      clr_v[UIP_SRC_XOFF] = xon_match;
      pend_nxt = (pend_r & ~clr_v) | set_v; // set wins over clear
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r <= 7'h00;
         below_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         below_r <= below;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rep_r <= UIP_REP_IDLE;
         held_r <= UIP_SRC_LS;
      end else begin
         unique case (rep_r)
            UIP_REP_IDLE: begin
               if (|elig && !stat_rd) begin
                  rep_r <= UIP_REP_HELD;
                  held_r <= top_idx;
               end
            end
            UIP_REP_HELD: begin
               if (stat_rd || !elig[held_r]) begin
                  rep_r <= UIP_REP_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= cur_valid & ~stat_rd;
      end
   end

   // ***********************************************
   // line format
   // ***********************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_r <= '0;
         thr_r <= `UIP_TXTRIG_0;
      end else begin
         thr_r <= trig_of(qc_r[`UIP_QC_TXTRIG_HI:`UIP_QC_TXTRIG_LO]);
         fmt_r.char_bits <= 4'h5 + {2'h0, lfc_r[1:0]};
         if (!lfc_r[`UIP_LF_STOP]) begin
            fmt_r.stop_halves <= `UIP_STOP_ONE;
         end else if (lfc_r[1:0] == 2'h0) begin
            fmt_r.stop_halves <= `UIP_STOP_ONE_HALF;
         end else begin
            fmt_r.stop_halves <= `UIP_STOP_TWO;
         end
         fmt_r.parity_en <= lfc_r[`UIP_LF_PEN];
         fmt_r.parity_even <= lfc_r[`UIP_LF_PEVEN];
         fmt_r.parity_force <= lfc_r[`UIP_LF_PFORCE];
         fmt_r.break_on <= lfc_r[`UIP_LF_BREAK];
      end
   end

   // tx line is released one cycle after the break bit is cleared
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_pin_r <= 1'b1;
         tx_par_r <= 1'b0;
         rx_err_r <= 1'b0;
      end else begin
         tx_pin_r <= lfc_r[`UIP_LF_BREAK] ? 1'b0 : tx_serial;
         tx_par_r <= lfc_r[`UIP_LF_PEN] & par_of(tx_char, lfc_r);
         rx_err_r <= lfc_r[`UIP_LF_PEN] &
                     (rx_parity_bit != par_of(rx_char, lfc_r));
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign irq = irq_r;
   assign tx_pin = tx_pin_r;
   assign tx_parity = tx_par_r;
   assign rx_parity_err = rx_err_r;
   assign fmt = fmt_r;
   assign queues_on = qc_r[`UIP_QC_ENABLE];
   assign tx_threshold = thr_r;
   assign divisor = div_r;

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_stat_read;
      stat_rd;
   endsequence
   sequence s_stat_none;
      stat_rd && !cur_valid;
   endsequence

   AST_TXTRIG: assert property (1'b1 |=> thr_r ==
      trig_of($past(qc_r[5:4]))) else $error("tx threshold wrong");
   AST_HOLD: assert property (rep_r == UIP_REP_HELD && !stat_rd
      |=> held_r == $past(held_r)) else $error("held source changed");
   AST_CLEAR: assert property (s_stat_read ##0 (cur_valid &&
      cur_idx != UIP_SRC_XOFF && !set_v[cur_idx] && !xon_match) |=>
      ($past(pend_r) & ~pend_r) == (7'h01 << $past(cur_idx)))
      else $error("read cleared wrong source");
   AST_TOPCODE: assert property (s_stat_read ##0 (cur_valid &&
      cur_idx == UIP_SRC_LS) |=> hrdata_r[5:0] == 6'h06)
      else $error("line status code wrong");
   AST_XOFF: assert property (pend_r[5] && !xon_match
      |=> pend_r[5]) else $error("xoff flag dropped");
   AST_ENH: assert property (s_stat_read ##0 !efc_r[4]
      |=> hrdata_r[5:4] == 2'h0) else $error("upper code bits shown");
   AST_QEN: assert property (s_stat_read
      |=> hrdata_r[7:6] == {2{$past(qc_r[0])}})
      else $error("queue flags wrong");
   AST_NONE: assert property (s_stat_none
      |=> hrdata_r[5:0] == 6'h01) else $error("idle code wrong");
   AST_IRQ: assert property (cur_valid && !stat_rd
      |=> irq_r) else $error("irq missing");
   AST_BREAK: assert property (lfc_r[6] |=> !tx_pin_r)
      else $error("break not driven");
   AST_QCW: assert property (wr_pend_r && wr_addr_r == 8'h08 &&
      !hwdata[0] |=> qc_r == 8'h00) else $error("queue bits written");
   AST_DIV: assert property (wr_pend_r && !lfc_r[7]
      |=> div_r == $past(div_r) && efc_r == $past(efc_r))
      else $error("locked register written");
   AST_NOPAR: assert property (!lfc_r[3] |=> !rx_err_r)
      else $error("parity error without parity");
endmodule

// ### tb/uip_chan_model.sv
/*
 * channel-side model: event pulses, xon match, queue level, serial bits.
 * assumes hclk from the bench; outputs change just after rising edges.
 */
`timescale 1ns/1ps
module uip_chan_model
   import uip_pkg::*;
(
   // clock
   input wire logic hclk,
   // channel outputs
   output uip_evt_t evt,
   output logic xon_match,
   output logic [6:0] tx_level,
   output logic tx_serial
);
   initial begin
      evt = '0;
      xon_match = 1'h0;
      tx_level = 7'h3F;
      tx_serial = 1'h1;
   end
   // flips every cycle so a stale copy of the line never passes
   always @(posedge hclk) tx_serial <= ~tx_serial;
   task automatic pulse(input uip_evt_t m);
      @(posedge hclk);
      evt <= m;
      @(posedge hclk);
      evt <= '0;
   endtask
   task automatic xon();
      @(posedge hclk);
      xon_match <= 1'h1;
      @(posedge hclk);
      xon_match <= 1'h0;
   endtask
endmodule

// ### tb/uip_top_test.sv
/*
 * self-checking bench for uip_top over AHB-Lite.
 * assumes uip_chan_model plays the channel logic on the same clock.
 */
`timescale 1ns/1ps
`include "uip_cfg.svh"
module uip_top_test import uip_pkg::*;;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] tx_char = 8'hB5;
   logic [7:0] rx_char = 8'hB5;
   logic rx_parity_bit = 1'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq, tx_pin, tx_parity, rx_parity_err;
   logic queues_on, xon_match, tx_serial;
   logic [6:0] tx_threshold, tx_level;
   logic [15:0] divisor;
   uip_fmt_t fmt;
   uip_evt_t evt;
   int n_fail = 0;
   int checks = 0;
   always #25 hclk = ~hclk;
   uip_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .evt(evt),
      .xon_match(xon_match), .tx_level(tx_level), .tx_char(tx_char),
      .tx_serial(tx_serial), .rx_char(rx_char),
      .rx_parity_bit(rx_parity_bit), .irq(irq), .tx_pin(tx_pin),
      .tx_parity(tx_parity), .rx_parity_err(rx_parity_err), .fmt(fmt),
      .queues_on(queues_on), .tx_threshold(tx_threshold),
      .divisor(divisor));
   uip_chan_model u_chan (.hclk(hclk), .evt(evt), .xon_match(xon_match),
      .tx_level(tx_level), .tx_serial(tx_serial));
   // ***********************************************
   // checks and bus cycles
   // ***********************************************
   task automatic complete_run();
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, exp, input string m);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // the wait loops rely on the watchdog to cut a hang short
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'h1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string m);
      logic [31:0] q;
      bus(a, 1'h0, 32'h0, q);
      chk_val(q, e, m);
   endtask
   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_reset();
      chk_val(irq, 0, "irq at reset");
      chk_val(tx_pin, 1, "tx idle");
      chk_val(hresp, 0, "resp okay");
      rd(`UIP_OFS_IRQ_STATUS, 32'h01, "status idle");
      rd(`UIP_OFS_LINE_FMT, 32'h00, "line fmt reset");
      chk_val(fmt, 32'h2A0, "fmt reset");
      chk_val(tx_threshold, 8, "threshold reset");
   endtask
   task automatic t_trig();
      logic [6:0] tt [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
      for (int i = 0; i < 4; i++) begin
         wr(`UIP_OFS_QUEUE_CTRL, 32'(i * 16 + 1));
         idle(2);
         chk_val(tx_threshold, tt[i], "threshold");
      end
      rd(`UIP_OFS_IRQ_STATUS, 32'hC1, "queues on flags");
      wr(`UIP_OFS_QUEUE_CTRL, 32'h30);
      idle(2);
      chk_val({queues_on, tx_threshold}, 8, "no enable");
      rd(`UIP_OFS_BLOCK_STATE, 32'h08, "block state");
      rd(`UIP_OFS_IRQ_STATUS, 32'h01, "queues off flags");
   endtask
   task automatic t_prio();
      logic [7:0] sq [7] = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00,
                             8'h10, 8'h10};
      wr(`UIP_OFS_IRQ_ENABLE, 32'h7F);
      u_chan.pulse(7'h08);
      idle(4);
      u_chan.pulse(7'h01);
      idle(4);
      rd(`UIP_OFS_IRQ_STATUS, 32'h02, "held source");
      idle(3);
      rd(`UIP_OFS_IRQ_STATUS, 32'h06, "next source");
      idle(3);
      wr(`UIP_OFS_LINE_FMT, 32'h80);
      wr(`UIP_OFS_ENH_FUNC, 32'h10);
      wr(`UIP_OFS_LINE_FMT, 32'h00);
      u_chan.pulse(7'h7F);
      idle(4);
      chk_val(irq, 1, "irq pending");
      for (int i = 0; i < 7; i++) begin
         rd(`UIP_OFS_IRQ_STATUS, sq[i], "priority order");
         idle(3);
      end
      u_chan.xon();
      idle(4);
      rd(`UIP_OFS_IRQ_STATUS, 32'h20, "flow change");
      idle(3);
      rd(`UIP_OFS_IRQ_STATUS, 32'h01, "all served");
      idle(3);
      chk_val(irq, 0, "irq idle");
   endtask
   task automatic t_enh_off();
      wr(`UIP_OFS_LINE_FMT, 32'h80);
      wr(`UIP_OFS_ENH_FUNC, 32'h00);
      wr(`UIP_OFS_LINE_FMT, 32'h00);
      u_chan.pulse(7'h60);
      idle(4);
      rd(`UIP_OFS_IRQ_STATUS, 32'h01, "upper codes hidden");
      chk_val(irq, 0, "upper sources masked");
   endtask
   task automatic t_div();
      wr(`UIP_OFS_DIVISOR, 32'h1234);
      idle(2);
      chk_val(divisor, 0, "divisor locked");
      rd(`UIP_OFS_DIVISOR, 32'h0, "divisor hidden");
      wr(`UIP_OFS_LINE_FMT, 32'h80);
      wr(`UIP_OFS_DIVISOR, 32'h1234);
      idle(2);
      chk_val(divisor, 32'h1234, "divisor open");
      rd(`UIP_OFS_DIVISOR, 32'h1234, "divisor read");
      wr(`UIP_OFS_LINE_FMT, 32'h00);
   endtask
   task automatic t_break();
      wr(`UIP_OFS_LINE_FMT, 32'h40);
      idle(2);
      repeat (6) begin
         @(negedge hclk);
         chk_val(tx_pin, 0, "break held");
      end
      wr(`UIP_OFS_LINE_FMT, 32'h00);
      idle(2);
      repeat (4) begin
         @(negedge hclk);
         chk_val(tx_pin, {31'h0, ~tx_serial}, "line follows");
      end
   endtask
   task automatic t_fmt();
      logic [7:0] lv [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07,
                              8'h08, 8'h1B, 8'h28, 8'h38};
      logic [7:0] f;
      logic o, p;
      uip_fmt_t e;
      for (int i = 0; i < 10; i++) begin
         f = lv[i];
         wr(`UIP_OFS_LINE_FMT, {24'h0, f});
         idle(2);
         e.char_bits = 4'(5 + f[1:0]);
         e.stop_halves = !f[2] ? 3'h2 : (f[1:0] == 2'h0) ? 3'h3 : 3'h4;
         e.parity_en = f[3];
         e.parity_even = f[4];
         e.parity_force = f[5];
         e.break_on = 1'h0;
         chk_val(fmt, e, "format");
         // odd parity bit makes the total count of ones odd
         o = ^(tx_char & (8'hFF >> (3 - f[1:0])));
         p = !f[3] ? 1'h0 : f[5] ? ~f[4] : f[4] ? o : ~o;
         chk_val(tx_parity, p, "tx parity");
         rx_parity_bit <= p;
         idle(2);
         chk_val(rx_parity_err, 0, "rx parity good");
         rx_parity_bit <= ~p;
         idle(2);
         chk_val(rx_parity_err, f[3], "rx parity bad");
      end
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset();
      t_trig();
      t_prio();
      t_enh_off();
      t_div();
      t_break();
      t_fmt();
      complete_run();
   end
   // whole run needs well under 2000 cycles
   initial begin
      #1000000;
      n_fail++;
      complete_run();
   end
endmodule
